// ---- adcsq_core_model.sv ----
// converter core model: answers each start with a channel-coded result
`timescale 1ns/10ps
module adcsq_core_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] lat,
    input  wire logic [2:0] ana_channel,
    input  wire logic       ana_start,
    output logic      [9:0] ana_result,
    output logic            ana_done
);
    logic [3:0] cnt_r;
    logic       busy_r;
    logic [9:0] res_r;
    // count out the conversion, then pulse done once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 4'h0;
            busy_r <= 1'b0;
            res_r <= 10'h000;
            ana_done <= 1'b0;
        end else begin
            ana_done <= 1'b0;
            if (ana_start) begin
                busy_r <= 1'b1;
                cnt_r <= lat;
                res_r <= {ana_channel, ana_channel, ana_channel, 1'b1};
            end else if (busy_r && cnt_r == 4'h0) begin
                ana_done <= 1'b1;
                busy_r <= 1'b0;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
    // result is only meaningful with done; otherwise show its inverse
    assign ana_result = ana_done ? res_r : ~res_r;
endmodule

// ---- adcsq_ctrl.sv ----
// converter sequencer control: APB registers, scan state machine, flags
//
// Functional notes
// (R1) alignment bit 1 puts result in 15..6, else in 9..0, rest zero
// (R2) continuous mode rescans start..end channels until software stops
// (R3) one-time mode converts each range channel once then stops
// (R4) trigger source 0 software, 1 timer, 3 external pin, 2 reserved
// (R5) external source starts on falling edge of trigger pin
// (R6) timer source starts on each timer underflow pulse
// (R7) sampling lasts field value plus two conversion clocks
// (R8) read-only field shows channel being converted, resets to 0
// (R9) busy rises at accepted trigger, falls when run bit clears
// (R10) completion while complete flag set overwrites result, sets overwrite
// (R11) overwrite flag clears only by writing 1
// (R12) overwrite flag and its enable drive overwrite interrupt
// (R13) each conversion loads result and sets complete flag
// (R14) complete flag and its enable drive completion interrupt
// (R15) reading result register clears complete flag
// (R16) complete flag stays set on an overwrite
// (R17) software checks overwrite flag after reading result
// (R18) software writes run bit to start; hardware sets it otherwise
// (R19) one-time mode clears run bit at end; continuous stops by write 0
// (R20) disabled converter ignores triggers, but running scan continues
// (R21) channels converted ascending from start to end field
// (R22) reserved bits read zero and ignore writes
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
module adcsq_ctrl
    import adcsq_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_trigger_n,
    input  wire logic        timer_underflow,
    input  wire logic [9:0]  ana_result,
    input  wire logic        ana_done,
    output logic      [2:0]  ana_channel,
    output logic             ana_sample,
    output logic             ana_start,
    output logic             irq_complete,
    output logic             irq_overwrite
);
    import adcsq_pkg::*;

    adcsq_trig_if trig_if ();

    adcsq_state_type state_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [2:0]  end_channel_r;
    logic [2:0]  start_channel_r;
    logic        result_align_sel_r;
    logic        scan_mode_sel_r;
    logic [1:0]  trigger_source_sel_r;
    logic [2:0]  sample_time_sel_r;
    logic        overwrite_irq_en_r;
    logic        complete_irq_en_r;
    logic        converter_enable_r;
    logic        run_bit_r;
    logic [2:0]  current_channel_r;
    logic [3:0]  samp_cnt_r;
    logic        ana_sample_r;
    logic        ana_start_r;
    logic [15:0] result_r;
    logic        complete_flag_r;
    logic        overwrite_flag_r;
    logic        irq_complete_r;
    logic        irq_overwrite_r;
    logic        conv_tick;
    logic        hit_result;
    logic        hit_trig;
    logic        hit_ctrl;
    logic        setup;
    logic        wr_en;
    logic        rd_en;
    logic        wr_ctrl;
    logic        rd_result;
    logic        start_req;
    logic        stop_req;
    logic        enter_sample;
    logic        done_evt;
    logic        last_ch;
    logic [15:0] rd_mux;
    logic [15:0] result_nxt;

    // word-aligned address compare against a register index
    function automatic logic adcsq_hit(input logic [31:0] addr, input logic [15:0] idx);
        return addr == {14'h0000, idx, 2'b00};
    endfunction

    // last sampling count, sampling takes stime plus two ticks
    function automatic logic [3:0] adcsq_samp_last(input logic [2:0] stime);
        return 4'({1'b0, stime} + SAMPLE_BASE - 4'h1);
    endfunction

    adcsq_trig u_trig (
        .pclk            (pclk),
        .presetn         (presetn),
        .ext_trigger_n   (ext_trigger_n),
        .timer_underflow (timer_underflow),
        .trig            (trig_if.det)
    );

    adcsq_div u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (enter_sample),
        .tick    (conv_tick)
    );

    assign trig_if.trigger_source_sel = trigger_source_sel_r;
    assign trig_if.converter_enable   = converter_enable_r;

    // bus decode and transfer qualifiers
    always_comb begin
        hit_result = adcsq_hit(paddr, RESULT_IDX);
        hit_trig   = adcsq_hit(paddr, TRIGSEL_IDX);
        hit_ctrl   = adcsq_hit(paddr, CTRL_IDX);
        setup      = psel && !penable;
        wr_en      = psel && penable && pready_r && pwrite && !pslverr_r;
        rd_en      = psel && penable && pready_r && !pwrite && !pslverr_r;
        wr_ctrl    = wr_en && hit_ctrl;
        rd_result  = rd_en && hit_result;
    end

    // (R22) read mux with reserved bits at zero
    always_comb begin
        rd_mux = 16'h0000;
        if (hit_result) begin
            rd_mux = result_r;
        end else if (hit_trig) begin
            rd_mux[END_CH_LSB +: 3]   = end_channel_r;
            rd_mux[START_CH_LSB +: 3] = start_channel_r;
            rd_mux[ALIGN_BIT]         = result_align_sel_r;
            rd_mux[SCAN_BIT]          = scan_mode_sel_r;
            rd_mux[TSRC_LSB +: 2]     = trigger_source_sel_r;
            rd_mux[STIME_LSB +: 3]    = sample_time_sel_r;
        end else if (hit_ctrl) begin
            // (R8) channel indicator readback
            rd_mux[CUR_CH_LSB +: 3] = current_channel_r;
            rd_mux[BUSY_BIT]        = run_bit_r;
            rd_mux[OVR_BIT]         = overwrite_flag_r;
            rd_mux[CMP_BIT]         = complete_flag_r;
            rd_mux[OVR_IE_BIT]      = overwrite_irq_en_r;
            rd_mux[CMP_IE_BIT]      = complete_irq_en_r;
            rd_mux[RUN_BIT]         = run_bit_r;
            rd_mux[EN_BIT]          = converter_enable_r;
        end
    end

    // apb answer: one wait-free access phase, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r  <= {16'h0000, rd_mux};
            pready_r  <= 1'b1;
            pslverr_r <= !(hit_result || hit_trig || hit_ctrl);
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // (R4) (R21) (R22) trigger and channel select register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            end_channel_r        <= CH_RST;
            start_channel_r      <= CH_RST;
            result_align_sel_r   <= 1'b0;
            scan_mode_sel_r      <= 1'b0;
            trigger_source_sel_r <= TSRC_RST;
            sample_time_sel_r    <= STIME_RST;
        end else if (wr_en && hit_trig) begin
            end_channel_r        <= pwdata[END_CH_LSB +: 3];
            start_channel_r      <= pwdata[START_CH_LSB +: 3];
            result_align_sel_r   <= pwdata[ALIGN_BIT];
            scan_mode_sel_r      <= pwdata[SCAN_BIT];
            trigger_source_sel_r <= pwdata[TSRC_LSB +: 2];
            sample_time_sel_r    <= pwdata[STIME_LSB +: 3];
        end
    end

    // control bits held by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overwrite_irq_en_r <= 1'b0;
            complete_irq_en_r  <= 1'b0;
            converter_enable_r <= 1'b0;
        end else if (wr_ctrl) begin
            overwrite_irq_en_r <= pwdata[OVR_IE_BIT];
            complete_irq_en_r  <= pwdata[CMP_IE_BIT];
            converter_enable_r <= pwdata[EN_BIT];
        end
    end

    // start, stop and scan progress conditions
    always_comb begin
        // (R18) (R20) trigger accepted only when enabled and idle
        start_req = converter_enable_r && state_r == ST_IDLE &&
                    ((trigger_source_sel_r == TSRC_SW && wr_ctrl && pwdata[RUN_BIT]) ||
                     trig_if.hw_trig);
        // (R19) software stop by writing 0 to the run bit
        stop_req     = run_bit_r && wr_ctrl && !pwdata[RUN_BIT];
        done_evt     = state_r == ST_CONVERT && ana_done && !stop_req;
        last_ch      = current_channel_r == end_channel_r;
        enter_sample = start_req || (done_evt && (!last_ch || scan_mode_sel_r));
    end

    // scan state machine, channel pointer and converter handshake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r           <= ST_IDLE;
            run_bit_r         <= 1'b0;
            current_channel_r <= CH_RST;
            samp_cnt_r        <= 4'h0;
            ana_sample_r      <= 1'b0;
            ana_start_r       <= 1'b0;
        end else begin
            ana_start_r <= 1'b0;
            if (stop_req) begin
                state_r      <= ST_IDLE;
                run_bit_r    <= 1'b0;
                ana_sample_r <= 1'b0;
            end else begin
                unique case (state_r)
                    ST_IDLE: begin
                        // (R9) (R18) busy and run set at the trigger
                        if (start_req) begin
                            state_r           <= ST_SAMPLE;
                            run_bit_r         <= 1'b1;
                            current_channel_r <= start_channel_r;
                            samp_cnt_r        <= 4'h0;
                            ana_sample_r      <= 1'b1;
                        end
                    end
                    ST_SAMPLE: begin
                        // (R7) sampling length in conversion clocks
                        if (conv_tick) begin
                            if (samp_cnt_r == adcsq_samp_last(sample_time_sel_r)) begin
                                state_r      <= ST_CONVERT;
                                ana_sample_r <= 1'b0;
                                ana_start_r  <= 1'b1;
                            end else begin
                                samp_cnt_r <= samp_cnt_r + 4'h1;
                            end
                        end
                    end
                    ST_CONVERT: begin
                        if (done_evt) begin
                            samp_cnt_r <= 4'h0;
                            if (!last_ch) begin
                                // (R21) ascending channel order
                                state_r           <= ST_SAMPLE;
                                current_channel_r <= current_channel_r + 3'h1;
                                ana_sample_r      <= 1'b1;
                            end else if (scan_mode_sel_r) begin
                                // (R2) continuous rescan
                                state_r           <= ST_SAMPLE;
                                current_channel_r <= start_channel_r;
                                ana_sample_r      <= 1'b1;
                            end else begin
                                // (R3) (R19) one-time scan ends
                                state_r   <= ST_IDLE;
                                run_bit_r <= 1'b0;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // (R1) result alignment
    always_comb begin
        if (result_align_sel_r) begin
            result_nxt = {ana_result, 6'h00};
        end else begin
            result_nxt = {6'h00, ana_result};
        end
    end

    // (R13) result load on each completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r <= RESULT_RST;
        end else if (done_evt) begin
            result_r <= result_nxt;
        end
    end

    // (R13) (R15) (R16) complete flag, set wins over read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            complete_flag_r <= 1'b0;
        end else if (done_evt) begin
            complete_flag_r <= 1'b1;
        end else if (rd_result) begin
            complete_flag_r <= 1'b0;
        end
    end

    // (R10) (R11) overwrite flag, write 1 clears, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overwrite_flag_r <= 1'b0;
        end else if (done_evt && complete_flag_r && !rd_result) begin
            overwrite_flag_r <= 1'b1;
        end else if (wr_ctrl && pwdata[OVR_BIT]) begin
            overwrite_flag_r <= 1'b0;
        end
    end

    // (R12) (R14) interrupt requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_complete_r  <= 1'b0;
            irq_overwrite_r <= 1'b0;
        end else begin
            irq_complete_r  <= complete_flag_r && complete_irq_en_r;
            irq_overwrite_r <= overwrite_flag_r && overwrite_irq_en_r;
        end
    end

    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign ana_channel   = current_channel_r;
    assign ana_sample    = ana_sample_r;
    assign ana_start     = ana_start_r;
    assign irq_complete  = irq_complete_r;
    assign irq_overwrite = irq_overwrite_r;

    // helper: conversion ticks seen during the current sampling phase
    logic [3:0] chk_ticks_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chk_ticks_r <= 4'h0;
        end else if (enter_sample) begin
            chk_ticks_r <= 4'h0;
        end else if (state_r == ST_SAMPLE && conv_tick) begin
            chk_ticks_r <= chk_ticks_r + 4'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_last_done;
        done_evt && last_ch;
    endsequence

    sequence s_back_idle;
        !run_bit_r && state_r == ST_IDLE && !ana_sample_r;
    endsequence

    a_align_result: assert property (done_evt |=> // (R1)
        result_r == (result_align_sel_r ? {$past(ana_result), 6'h00}
                                        : {6'h00, $past(ana_result)}))
        else $error("result alignment wrong");
    a_scan_rewind: assert property (s_last_done ##0 scan_mode_sel_r |=> // (R2)
        run_bit_r && current_channel_r == $past(start_channel_r) && ana_sample_r)
        else $error("continuous scan did not restart");
    a_oneshot_end: assert property (s_last_done ##0 !scan_mode_sel_r |=> s_back_idle) // (R3)
        else $error("one-time scan did not stop");
    a_sample_len: assert property ($rose(ana_start_r) |-> // (R7)
        chk_ticks_r == 4'({1'b0, $past(sample_time_sel_r)} + SAMPLE_BASE))
        else $error("sampling length wrong");
    a_busy_trigger: assert property (start_req |=> run_bit_r && ana_sample_r) // (R9)
        else $error("busy not set at trigger");
    a_overwrite_set: assert property (done_evt && complete_flag_r && !rd_result |=> // (R10)
        overwrite_flag_r && complete_flag_r)
        else $error("overwrite not flagged");
    a_overwrite_hold: assert property (overwrite_flag_r && !(wr_ctrl && pwdata[OVR_BIT]) // (R11)
        |=> overwrite_flag_r)
        else $error("overwrite flag lost");
    a_irq_overwrite: assert property (overwrite_flag_r && overwrite_irq_en_r |=> // (R12)
        irq_overwrite_r)
        else $error("overwrite request missing");
    a_irq_complete: assert property (irq_complete_r |-> // (R14)
        $past(complete_flag_r) && $past(complete_irq_en_r))
        else $error("spurious completion request");
    a_read_clear: assert property (rd_result && !done_evt |=> !complete_flag_r) // (R15)
        else $error("read did not clear complete flag");
    a_enable_gate: assert property (state_r == ST_IDLE && !converter_enable_r |=> // (R20)
        state_r == ST_IDLE)
        else $error("trigger accepted while disabled");
    a_channel_step: assert property (done_evt && !last_ch |=> // (R21)
        current_channel_r == 3'($past(current_channel_r) + 3'h1))
        else $error("channel order wrong");
endmodule

// ---- adcsq_div.sv ----
// conversion clock enable divider
`timescale 1ns/10ps
module adcsq_div
    import adcsq_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic restart,
    output logic      tick
);
    logic [7:0] cnt_r;
    logic       tick_r;

    // one-cycle enable every CONV_DIV pclk cycles, realigned on restart so that
    // the first tick after restart lands exactly CONV_DIV cycles later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= 8'h00;
            tick_r <= 1'b0;
        end else if (restart) begin
            cnt_r  <= 8'h01; // registered tick costs one cycle, start one step ahead
            tick_r <= 1'b0;
        end else if (cnt_r == 8'(CONV_DIV - 1)) begin
            cnt_r  <= 8'h00;
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 8'h01;
            tick_r <= 1'b0;
        end
    end

    assign tick = tick_r;
endmodule

// ---- adcsq_pkg.sv ----
// shared constants and types for the converter sequencer control block
package adcsq_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] RESULT_IDX  = 16'h5380;
    localparam logic [15:0] TRIGSEL_IDX = 16'h5382;
    localparam logic [15:0] CTRL_IDX    = 16'h5384;

    // trigger_channel_select field positions
    localparam int END_CH_LSB   = 11;
    localparam int START_CH_LSB = 8;
    localparam int ALIGN_BIT    = 7;
    localparam int SCAN_BIT     = 6;
    localparam int TSRC_LSB     = 4;
    localparam int STIME_LSB    = 0;

    // control_status field positions
    localparam int CUR_CH_LSB = 12;
    localparam int BUSY_BIT   = 10;
    localparam int OVR_BIT    = 9;
    localparam int CMP_BIT    = 8;
    localparam int OVR_IE_BIT = 5;
    localparam int CMP_IE_BIT = 4;
    localparam int RUN_BIT    = 1;
    localparam int EN_BIT     = 0;

    // reset values
    localparam logic [2:0]  CH_RST     = 3'h0;
    localparam logic [2:0]  STIME_RST  = 3'h7;
    localparam logic [1:0]  TSRC_RST   = 2'h0;
    localparam logic [15:0] RESULT_RST = 16'h0000;

    // trigger source encodings
    localparam logic [1:0] TSRC_SW  = 2'h0;
    localparam logic [1:0] TSRC_TMR = 2'h1;
    localparam logic [1:0] TSRC_EXT = 2'h3;

    // timing: pclk cycles per conversion clock, base sampling cycles
    localparam int         CONV_DIV    = 2;
    localparam logic [3:0] SAMPLE_BASE = 4'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcsq_state_type;
endpackage

// ---- adcsq_trig.sv ----
// hardware trigger detector: timer underflow and external pin falling edge
`timescale 1ns/10ps
module adcsq_trig
    import adcsq_pkg::*;
(
    input  wire logic    pclk,
    input  wire logic    presetn,
    input  wire logic    ext_trigger_n,
    input  wire logic    timer_underflow,
    adcsq_trig_if.det    trig
);
    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic hw_trig_r;

    // two-stage synchroniser plus an edge history stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            sync3_r <= 1'b1;
        end else begin
            sync1_r <= ext_trigger_n;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // (R5) (R6) source select and edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw_trig_r <= 1'b0;
        end else begin
            hw_trig_r <= trig.converter_enable &&
                         ((trig.trigger_source_sel == TSRC_EXT && sync3_r && !sync2_r) ||
                          (trig.trigger_source_sel == TSRC_TMR && timer_underflow));
        end
    end

    assign trig.hw_trig = hw_trig_r;
endmodule

// ---- adcsq_trig_if.sv ----
// trigger selection signals between the control core and the trigger detector
`timescale 1ns/10ps
interface adcsq_trig_if;
    logic [1:0] trigger_source_sel;
    logic       converter_enable;
    logic       hw_trig;
    modport ctl (output trigger_source_sel, output converter_enable, input hw_trig);
    modport det (input trigger_source_sel, input converter_enable, output hw_trig);
endinterface

// ---- tb_top.sv ----
// self-checking bench for the converter sequencer control block
`timescale 1ns/10ps
module tb_top;
    import adcsq_pkg::*;
    localparam logic [31:0] A_RES = {14'h0, RESULT_IDX, 2'h0};
    localparam logic [31:0] A_TRG = {14'h0, TRIGSEL_IDX, 2'h0};
    localparam logic [31:0] A_CTL = {14'h0, CTRL_IDX, 2'h0};
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rv;
    logic        pready, pslverr, serr;
    logic        timer_underflow = 1'b0, ext_trigger_n = 1'b1;
    logic [9:0]  ana_result;
    logic        ana_done, ana_sample, ana_start, irq_complete, irq_overwrite;
    logic [2:0]  ana_channel;
    logic [3:0]  lat = 4'h3;
    logic [7:0]  samp_cnt = 8'h0;
    logic [2:0]  chq[$];
    int          num_errors = 0;
    int          n_checks = 0;
    always #4 pclk = ~pclk;
    adcsq_ctrl i_adcsq_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_trigger_n, .timer_underflow, .ana_result,
        .ana_done, .ana_channel, .ana_sample, .ana_start, .irq_complete, .irq_overwrite);
    adcsq_core_model i_adcsq_core_model (.pclk, .presetn, .lat, .ana_channel,
        .ana_start, .ana_result, .ana_done);
    // record the channel of each start and the sampling length before it
    always @(posedge pclk) begin
        if (ana_start) chq.push_back(ana_channel);
        samp_cnt <= ana_sample ? samp_cnt + 8'h1 : 8'h0;
    end
    function automatic logic [9:0] code_of(input logic [2:0] c);
        return {c, c, c, 1'b1};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one APB transfer; read data and error taken at the pready edge
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task idle();
        do apb(1'b0, A_CTL, 32'h0); while (rv[BUSY_BIT] !== 1'b0);
    endtask
    task t_reset();
        apb(1'b0, A_TRG, 32'h0);
        chk(rv, 32'h7);
        apb(1'b0, A_CTL, 32'h0);
        chk(rv, 32'h0);
        apb(1'b0, 32'h0, 32'h0);
        chk(32'(serr), 32'h1);
        apb(1'b1, A_TRG, 32'hFFFFFFFF);
        apb(1'b0, A_TRG, 32'h0);
        chk(rv, 32'h3FF7);
    endtask
    task t_single(input logic al, input logic [2:0] ch, input logic [2:0] st);
        apb(1'b1, A_TRG, {18'h0, ch, ch, al, 4'h0, st});
        // enable first: a run write is only taken once the converter is enabled
        apb(1'b1, A_CTL, 32'h1);
        apb(1'b1, A_CTL, 32'h3);
        @(posedge pclk);
        while (ana_start !== 1'b1) @(posedge pclk);
        chk(32'(ana_channel), 32'(ch));
        chk(32'(samp_cnt), 32'(2 * (st + 2)));
        idle();
        chk(rv, {17'h0, ch, 12'h101});
        apb(1'b0, A_RES, 32'h0);
        chk(rv, al ? {16'h0, code_of(ch), 6'h0} : {22'h0, code_of(ch)});
        apb(1'b0, A_CTL, 32'h0);
        chk(rv, {17'h0, ch, 12'h001});
    endtask
    task t_scan();
        lat <= 4'hC;
        chq.delete();
        apb(1'b1, A_TRG, 32'h3D00);
        apb(1'b1, A_CTL, 32'h33);
        apb(1'b0, A_CTL, 32'h0);
        chk(rv & 32'h402, 32'h402);
        idle();
        chk(32'(chq.size()), 32'h3);
        foreach (chq[i]) chk(32'(chq[i]), 32'(i + 5));
        chk(rv, 32'h7331);
        chk(32'({irq_overwrite, irq_complete}), 32'h3);
        apb(1'b1, A_CTL, 32'h31);
        apb(1'b0, A_CTL, 32'h0);
        chk(rv, 32'h7331);
        apb(1'b1, A_CTL, 32'h231);
        apb(1'b0, A_RES, 32'h0);
        chk(rv, {22'h0, code_of(3'h7)});
        apb(1'b0, A_CTL, 32'h0);
        chk(rv, 32'h7031);
        chk(32'({irq_overwrite, irq_complete}), 32'h0);
    endtask
    task t_cont();
        lat <= 4'h1;
        chq.delete();
        apb(1'b1, A_TRG, 32'h0740);
        apb(1'b1, A_CTL, 32'h3);
        while (chq.size() < 5) @(posedge pclk);
        foreach (chq[i]) chk(32'(chq[i]), i[0] ? 32'h0 : 32'h7);
        apb(1'b1, A_CTL, 32'h1);
        apb(1'b0, A_CTL, 32'h0);
        chk(rv & 32'h402, 32'h0);
    endtask
    // every trigger code, then the timer with the converter disabled
    task t_trig();
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, A_TRG, 32'(k == 4 ? 1 : k) << 4);
            apb(1'b1, A_CTL, k < 4 ? 32'h1 : 32'h0);
            chq.delete();
            timer_underflow <= 1'b1;
            ext_trigger_n <= 1'b0;
            @(posedge pclk);
            timer_underflow <= 1'b0;
            repeat (40) @(posedge pclk);
            chk(32'(chq.size()), (k == 1 || k == 3) ? 32'h1 : 32'h0);
            ext_trigger_n <= 1'b1;
            idle();
        end
    endtask
    task wrap_up();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_single(1'b0, 3'h3, 3'h0);
        t_single(1'b1, 3'h5, 3'h7);
        t_scan();
        t_cont();
        t_trig();
        wrap_up();
    end
    // cut a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        wrap_up();
    end
endmodule
